// *** common/bsp_pkg.sv ***
`default_nettype none
package bsp_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_HZ          = 125_000_000;
   localparam int unsigned OSC_DEFAULT_KHZ = 200;
   localparam int unsigned OSC_DIV_CYC     = CLK_HZ / (OSC_DEFAULT_KHZ * 1000);
   localparam int unsigned SS_RAMP_OSC     = 1024;
   localparam int unsigned SS_DELAY_OSC    = 64;
   localparam int unsigned PG_DELAY_OSC    = 3;
   localparam int unsigned UV_RETRY_OSC    = 64;
   localparam int unsigned OCP_SLOW_CNT    = 4;
   localparam int unsigned SYNC_DELAY_CYC  = 16;
   localparam int unsigned US_TIMER_US     = 30;
   localparam int unsigned US_TIMER_CYC    = US_TIMER_US * (CLK_HZ / 1_000_000);
   localparam int unsigned UV_ENABLE_PCT   = 80;
   localparam int unsigned UV_ENABLE_STEP  = SS_RAMP_OSC * UV_ENABLE_PCT / 100;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      BSP_DISABLED = 3'h0,
      BSP_SS_DELAY = 3'h1,
      BSP_SS_RAMP  = 3'h2,
      BSP_PG_WAIT  = 3'h3,
      BSP_RUN      = 3'h4,
      BSP_UV_RETRY = 3'h5
   } bsp_phase_type;

   typedef struct packed {
      logic high_side_gate;
      logic low_side_gate;
      logic bleed_on;
   } bsp_gate_type;

   typedef struct packed {
      logic overvoltage_latch;
      logic undervoltage_latch;
      logic overcurrent_slow_trip;
      logic overcurrent_fast_trip;
   } bsp_fault_type;

endpackage
`default_nettype wire

// *** rtl/bsp_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Unprogrammed oscillator ticks at 200 kHz.
// - Enable pin grounded means disabled state.
// - Start needs both supplies good, enable released.
// - Fixed delay, then 1024 tick reference ramp.
// - Power good released three ticks after ramp.
// - Overvoltage watched whenever enabled, soft-start included.
// - Undervoltage armed at 80%, retries during start.
// - Switching aligns to sync falling edge.
// - Power good low in start and voltage faults.
// - Output above 125% latches overvoltage.
// - Overvoltage: high low, low-side high, then bleed.
// - Overvoltage latch cleared by supply or enable.
// - Undervoltage after start latches, gates low.
// - Disabled guard: low-side gate on at pre-overvoltage with supply good.
// - Four cycles mid current trips slow latch.
// - Above 30 mV trips fast latch immediately.
// - Overcurrent latches held until supply or enable.
// - Light load turns low-side off at zero current.
// - Ultrasonic timer restarts on high-side turn-off.
// - Timer expiry forces low-side gate on.
// - Light load interleaves with sync in range.
module bsp_top #(
   parameter int unsigned OSC_DIV    = bsp_pkg::OSC_DIV_CYC,
   parameter int unsigned US_TIMEOUT = bsp_pkg::US_TIMER_CYC
) (
   input  wire logic          clk_i,
   input  wire logic          rst_b_i,
   input  wire logic          supply_ok_i,
   input  wire logic          driver_supply_ok_i,
   input  wire logic          freq_set_enable_pin_low_i,
   input  wire logic          osc_tick_ext_i,
   input  wire logic          osc_ext_sel_i,
   input  wire logic          sync_enable_i,
   input  wire logic          sync_i,
   input  wire logic          sync_in_range_i,
   input  wire logic          pwm_request_i,
   input  wire logic          output_sense_ov_i,
   input  wire logic          output_sense_below_half_i,
   input  wire logic          output_sense_pre_ov_i,
   input  wire logic          output_sense_in_window_i,
   input  wire logic          feedback_input_uv_i,
   input  wire logic          current_sense_over20_i,
   input  wire logic          current_sense_over30_i,
   input  wire logic          switch_node_zero_current_i,
   input  wire logic          light_load_i,
   output logic               high_side_gate_o,
   output logic               low_side_gate_o,
   output logic               bleed_on_o,
   output logic               power_good_out_o,
   output logic               power_good_out_oe_o,
   output logic               osc_tick_o,
   output logic               ramp_reset_o,
   output logic [9:0]         reference_step_o,
   output bsp_pkg::bsp_phase_type phase_o,
   output bsp_pkg::bsp_fault_type fault_o
);
   import bsp_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      bsp_phase_type phase;
      bsp_fault_type fault;
      bsp_gate_type  gate;
      logic [15:0]   div;
      logic [10:0]   step;
      logic [15:0]   us_cnt;
      logic [2:0]    ocp_cnt;
      logic [7:0]    sync_dly;
      logic          sync_prev;
      logic          sync_armed;
      logic [9:0]    ref_step;
      logic          us_expired;
      logic          tick;
      logic          ramp_reset;
      logic          pg_low;
   } bsp_state_type;

   bsp_state_type st;
   bsp_state_type next_st;

   logic enabled_ok;
   logic tick_now;
   logic sync_fall;
   logic hs_req;
   logic any_off;

   assign enabled_ok = supply_ok_i & driver_supply_ok_i &
                       ~freq_set_enable_pin_low_i;
   assign sync_fall  = st.sync_prev & ~sync_i;
   assign any_off    = st.fault.undervoltage_latch |
                       st.fault.overcurrent_slow_trip |
                       st.fault.overcurrent_fast_trip;

   always_comb begin
      next_st            = st;
      next_st.sync_prev  = sync_i;
      next_st.ramp_reset = 1'b0;
      tick_now           = 1'b0;
      hs_req             = 1'b0;

      // ****************************************************************
      // Oscillator and sync
      // ****************************************************************
      // Ticks come from the divider unless a programmed oscillator is used.
      if (osc_ext_sel_i) begin
         tick_now = osc_tick_ext_i;
      end else if (st.div >= 16'(OSC_DIV - 1)) begin
         tick_now    = 1'b1;
         next_st.div = 16'h0000;
      end else begin
         next_st.div = st.div + 16'h0001;
      end
      // A sync edge restarts the ramp after a fixed delay, locking phase.
      // Edges inside the delay are ignored; re-arming on each of them would
      // starve the lock whenever the sync period is shorter than the delay.
      if (st.sync_armed) begin
         if (st.sync_dly >= 8'(SYNC_DELAY_CYC - 1)) begin
            next_st.sync_armed = 1'b0;
            next_st.ramp_reset = 1'b1;
            next_st.div        = 16'h0000;
            tick_now           = 1'b1;
         end else begin
            next_st.sync_dly = st.sync_dly + 8'h01;
         end
      end else if (sync_enable_i && sync_fall && sync_in_range_i) begin
         next_st.sync_armed = 1'b1;
         next_st.sync_dly   = 8'h00;
      end
      next_st.tick = tick_now;

      // ****************************************************************
      // Sequencer
      // ****************************************************************
      if (!enabled_ok) begin
         next_st.phase = BSP_DISABLED;
         next_st.fault = '0;
         next_st.step  = 11'h000;
      end else begin
         case (st.phase)
            BSP_DISABLED: begin
               next_st.phase = BSP_SS_DELAY;
               next_st.step  = 11'h000;
            end
            BSP_SS_DELAY, BSP_UV_RETRY: begin
               if (tick_now) begin
                  next_st.step = st.step + 11'h001;
               end
               if (tick_now && st.step >= 11'(SS_DELAY_OSC - 1)) begin
                  next_st.phase = BSP_SS_RAMP;
                  next_st.step  = 11'h000;
               end
            end
            BSP_SS_RAMP: begin
               if (tick_now) begin
                  next_st.step = st.step + 11'h001;
               end
               if (st.step >= 11'(UV_ENABLE_STEP) && feedback_input_uv_i) begin
                  next_st.phase = BSP_UV_RETRY;
                  next_st.step  = 11'h000;
               end else if (tick_now && st.step >= 11'(SS_RAMP_OSC - 1)) begin
                  next_st.phase = BSP_PG_WAIT;
                  next_st.step  = 11'h000;
               end
            end
            BSP_PG_WAIT: begin
               if (tick_now) begin
                  next_st.step = st.step + 11'h001;
               end
               if (feedback_input_uv_i) begin
                  next_st.fault.undervoltage_latch = 1'b1;
               end
               if (tick_now && st.step >= 11'(PG_DELAY_OSC - 1)) begin
                  next_st.phase = BSP_RUN;
               end
            end
            BSP_RUN: begin
               if (feedback_input_uv_i) begin
                  next_st.fault.undervoltage_latch = 1'b1;
               end
            end
            default: begin
               next_st.phase = BSP_DISABLED;
            end
         endcase
         if (output_sense_ov_i) begin
            next_st.fault.overvoltage_latch = 1'b1;
         end
         if (current_sense_over30_i) begin
            next_st.fault.overcurrent_fast_trip = 1'b1;
         end
         // Slow level counts switching cycles, so it samples on ticks only.
         if (tick_now) begin
            if (current_sense_over20_i && !current_sense_over30_i) begin
               next_st.ocp_cnt = st.ocp_cnt + 3'h1;
               if (st.ocp_cnt >= 3'(OCP_SLOW_CNT - 1)) begin
                  next_st.fault.overcurrent_slow_trip = 1'b1;
               end
            end else begin
               next_st.ocp_cnt = 3'h0;
            end
         end
      end
      if (!enabled_ok) begin
         next_st.ocp_cnt = 3'h0;
      end

      // ****************************************************************
      // Gates
      // ****************************************************************
      hs_req = pwm_request_i;
      next_st.gate = '0;
      if (!enabled_ok || st.phase == BSP_DISABLED) begin
         next_st.gate.low_side_gate = supply_ok_i &
                                      output_sense_pre_ov_i;
      end else if (st.fault.overvoltage_latch || output_sense_ov_i) begin
         if (output_sense_below_half_i) begin
            next_st.gate.bleed_on = 1'b1;
         end else begin
            next_st.gate.low_side_gate = 1'b1;
         end
      end else if (any_off) begin
         next_st.gate = '0;
      end else if (st.phase == BSP_SS_DELAY || st.phase == BSP_UV_RETRY) begin
         next_st.gate = '0;
      end else if (hs_req) begin
         next_st.gate.high_side_gate = 1'b1;
      end else if (st.us_expired) begin
         next_st.gate.low_side_gate = 1'b1;
      end else begin
         next_st.gate.low_side_gate = ~(light_load_i &
                                        switch_node_zero_current_i);
      end

      // ****************************************************************
      // Ultrasonic timer
      // ****************************************************************
      // Held clear while the high side is on, so it runs from turn-off.
      if (st.gate.high_side_gate) begin
         next_st.us_cnt     = 16'h0000;
         next_st.us_expired = 1'b0;
      end else if (st.us_cnt >= 16'(US_TIMEOUT - 1)) begin
         next_st.us_expired = 1'b1;
      end else begin
         next_st.us_cnt = st.us_cnt + 16'h0001;
      end

      // ****************************************************************
      // Power good and reference
      // ****************************************************************
      next_st.pg_low = (st.phase != BSP_RUN) ||
                       st.fault.overvoltage_latch ||
                       st.fault.undervoltage_latch ||
                       output_sense_ov_i;
      if (st.phase == BSP_RUN && !st.fault.overvoltage_latch &&
          !st.fault.undervoltage_latch && output_sense_in_window_i) begin
         next_st.pg_low = 1'b0;
      end
      // The reference step is registered so the output comes off a flop.
      next_st.ref_step = 10'h000;
      if (next_st.phase == BSP_SS_RAMP) begin
         next_st.ref_step = next_st.step[9:0];
      end else if (next_st.phase == BSP_PG_WAIT ||
                   next_st.phase == BSP_RUN) begin
         next_st.ref_step = 10'h3FF;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st       <= '0;
         st.phase <= BSP_DISABLED;
         st.pg_low <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign high_side_gate_o    = st.gate.high_side_gate;
   assign low_side_gate_o     = st.gate.low_side_gate;
   assign bleed_on_o          = st.gate.bleed_on;
   assign power_good_out_o    = 1'b0;
   assign power_good_out_oe_o = st.pg_low;
   assign osc_tick_o          = st.tick;
   assign ramp_reset_o        = st.ramp_reset;
   assign reference_step_o    = st.ref_step;
   assign phase_o             = st.phase;
   assign fault_o             = st.fault;

endmodule
`default_nettype wire

// *** sim/bsp_far_side.sv ***
`timescale 1ns/1ns
`default_nettype none
module bsp_far_side #(
   parameter int unsigned ZC_DLY = 3
) (
   input  wire logic clk_i,
   input  wire logic run_i,
   input  wire logic high_side_gate_i,
   input  wire logic low_side_gate_i,
   output logic      sync_o,
   output logic      zero_current_o
);
   int unsigned cnt;
   int unsigned lsc;
   // Inductor current falls while the low side conducts and stays at zero
   // once it gets there, until the next high-side pulse charges it again.
   always_ff @(posedge clk_i) begin
      cnt <= run_i ? cnt + 1 : 0;
      if (high_side_gate_i) begin
         lsc <= 0;
      end else if (low_side_gate_i && lsc < ZC_DLY) begin
         lsc <= lsc + 1;
      end
   end
   // Sync runs at the local rate, the lower edge of the lock window.
   assign sync_o = run_i ? cnt[1] : 1'b1;
   assign zero_current_o = (lsc >= ZC_DLY);
endmodule
`default_nettype wire

// *** sim/bsp_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module bsp_monitor #(
   parameter int unsigned OSC_DIV    = 4,
   parameter int unsigned US_TIMEOUT = 20
) (
   input wire logic                   clk_i,
   input wire logic                   rst_b_i,
   input wire logic                   supply_ok_i,
   input wire logic                   driver_supply_ok_i,
   input wire logic                   freq_set_enable_pin_low_i,
   input wire logic                   output_sense_ov_i,
   input wire logic                   output_sense_below_half_i,
   input wire logic                   output_sense_pre_ov_i,
   input wire logic                   feedback_input_uv_i,
   input wire logic                   current_sense_over20_i,
   input wire logic                   current_sense_over30_i,
   input wire logic                   high_side_gate_o,
   input wire logic                   low_side_gate_o,
   input wire logic                   bleed_on_o,
   input wire logic                   power_good_out_oe_o,
   input wire logic [9:0]             reference_step_o,
   input wire bsp_pkg::bsp_phase_type phase_o,
   input wire bsp_pkg::bsp_fault_type fault_o
);
   import bsp_pkg::*;
   logic en_ok;
   assign en_ok = supply_ok_i & driver_supply_ok_i &
                  ~freq_set_enable_pin_low_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   a_step_delay: assert property (
      phase_o inside {BSP_SS_DELAY, BSP_UV_RETRY}
      |-> reference_step_o == 10'h000)
      else $error("reference moved in start delay");
   a_pg_startup: assert property (
      phase_o inside {BSP_SS_DELAY, BSP_SS_RAMP, BSP_PG_WAIT,
                      BSP_UV_RETRY}
      |-> power_good_out_oe_o) else $error("power good released early");
   a_ov_latch: assert property (
      en_ok && phase_o != BSP_DISABLED && output_sense_ov_i
      |=> fault_o.overvoltage_latch) else $error("overvoltage not latched");
   a_ov_gates: assert property (
      en_ok && fault_o == 4'h8 && !output_sense_below_half_i
      |=> !high_side_gate_o && low_side_gate_o) else $error("ov gates");
   a_ov_bleed: assert property (
      en_ok && fault_o == 4'h8 && output_sense_below_half_i
      |=> bleed_on_o && !low_side_gate_o) else $error("ov bleed");
   a_oc_fast: assert property (
      en_ok && phase_o != BSP_DISABLED && current_sense_over30_i
      |=> fault_o.overcurrent_fast_trip) else $error("fast trip late");
   a_trip_gates: assert property (
      en_ok && !output_sense_ov_i && !fault_o[3] && fault_o[2:0] != 3'h0
      |=> !high_side_gate_o && !low_side_gate_o) else $error("trip gates");
   a_fault_hold: assert property (
      en_ok |=> (fault_o & $past(fault_o)) == $past(fault_o))
      else $error("fault dropped while enabled");
   a_fault_clear: assert property (
      !en_ok |=> fault_o == 4'h0) else $error("fault kept");
   a_guard_lg: assert property (
      (!en_ok && supply_ok_i && driver_supply_ok_i &&
       output_sense_pre_ov_i)[*2] |=> low_side_gate_o) else $error("guard");
   c_bleed: cover property (fault_o.overvoltage_latch && bleed_on_o);
   c_retry: cover property (phase_o == BSP_UV_RETRY);
   c_slow: cover property (fault_o.overcurrent_slow_trip);
endmodule
bind bsp_top bsp_monitor #(.OSC_DIV(OSC_DIV), .US_TIMEOUT(US_TIMEOUT))
   mon_u (.*);
`default_nettype wire

// *** sim/test_buck_sequencing_protection.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_buck_sequencing_protection;
   import bsp_pkg::*;
   localparam int unsigned DIV = 4;
   logic clk_i, rst_b_i, supply_ok_i, driver_supply_ok_i, run, sync_i;
   logic freq_set_enable_pin_low_i, osc_tick_ext_i, osc_ext_sel_i;
   logic sync_enable_i, sync_in_range_i, pwm_request_i, light_load_i;
   logic output_sense_ov_i, output_sense_below_half_i, output_sense_pre_ov_i;
   logic output_sense_in_window_i, feedback_input_uv_i, osc_tick_o;
   logic current_sense_over20_i, current_sense_over30_i, bleed_on_o;
   logic switch_node_zero_current_i, high_side_gate_o, low_side_gate_o;
   logic power_good_out_o, power_good_out_oe_o, ramp_reset_o;
   logic [9:0]    reference_step_o;
   bsp_phase_type phase_o;
   bsp_fault_type fault_o;
   int            fail_count;
   int            n_tests;
   bsp_top #(.OSC_DIV(DIV), .US_TIMEOUT(20)) dut_u (.*);
   bsp_far_side far_u (.clk_i(clk_i), .run_i(run),
      .high_side_gate_i(high_side_gate_o),
      .low_side_gate_i(low_side_gate_o), .sync_o(sync_i),
      .zero_current_o(switch_node_zero_current_i));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task results();
      if (fail_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task chk(input logic ok_v, input string m);
      n_tests++;
      if (ok_v !== 1'b1) begin
         fail_count++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   task tk(input int n);
      repeat (n) begin
         @(posedge clk_i);
         #1;
      end
   endtask
   task wtick(input int n);
      repeat (n) begin
         tk(1);
         while (osc_tick_o !== 1'b1) tk(1);
      end
   endtask
   task span(input bsp_phase_type p, output int n, output int c);
      n = 0;
      c = 0;
      while (phase_o !== p) tk(1);
      // A tick shows one edge after the cycle that used it, so it is
      // charged to the phase that the state held before that edge.
      while (phase_o === p) begin
         c++;
         tk(1);
         n += int'(osc_tick_o === 1'b1);
      end
   endtask
   task off_on();
      freq_set_enable_pin_low_i = 1'b1;
      tk(3);
      chk(fault_o === 4'h0 && phase_o === BSP_DISABLED, "toggle");
   endtask
   task start();
      int n;
      int c;
      wtick(1);
      freq_set_enable_pin_low_i = 1'b0;
      span(BSP_SS_DELAY, n, c);
      chk(n == SS_DELAY_OSC, "start delay");
      span(BSP_SS_RAMP, n, c);
      chk(n == SS_RAMP_OSC && c == SS_RAMP_OSC * DIV, "ramp");
      span(BSP_PG_WAIT, n, c);
      chk(n == PG_DELAY_OSC && power_good_out_oe_o === 1'b1, "pg");
      chk(power_good_out_o === 1'b0, "pg level");
      tk(1);
      chk(power_good_out_oe_o === 1'b0, "run pg");
      chk(reference_step_o === 10'h3FF, "run ref");
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task t_guard();
      supply_ok_i = 1'b1;
      driver_supply_ok_i = 1'b1;
      output_sense_pre_ov_i = 1'b1;
      tk(3);
      chk(low_side_gate_o === 1'b1, "guard");
      driver_supply_ok_i = 1'b0;
      freq_set_enable_pin_low_i = 1'b0;
      tk(3);
      chk(phase_o === BSP_DISABLED, "lockout");
      driver_supply_ok_i = 1'b1;
      tk(3);
      chk(!low_side_gate_o && phase_o === BSP_SS_DELAY, "enabled");
      output_sense_pre_ov_i = 1'b0;
      off_on();
   endtask
   task t_ov();
      freq_set_enable_pin_low_i = 1'b0;
      while (phase_o !== BSP_SS_RAMP) tk(1);
      output_sense_ov_i = 1'b1;
      tk(2);
      chk(fault_o === 4'h8 && low_side_gate_o === 1'b1, "ov");
      output_sense_ov_i = 1'b0;
      tk(5);
      chk(fault_o === 4'h8 && !high_side_gate_o, "ov hold");
      output_sense_below_half_i = 1'b1;
      tk(2);
      chk(bleed_on_o === 1'b1 && !low_side_gate_o, "bleed");
      output_sense_below_half_i = 1'b0;
      off_on();
      start();
   endtask
   task t_oc();
      current_sense_over20_i = 1'b1;
      wtick(3);
      current_sense_over20_i = 1'b0;
      wtick(1);
      chk(fault_o === 4'h0, "slow trip early");
      current_sense_over20_i = 1'b1;
      wtick(5);
      chk(fault_o === 4'h2 && !low_side_gate_o, "slow trip");
      current_sense_over20_i = 1'b0;
      off_on();
      start();
      current_sense_over30_i = 1'b1;
      pwm_request_i = 1'b1;
      tk(2);
      chk(fault_o === 4'h1 && !high_side_gate_o, "fast trip");
      current_sense_over30_i = 1'b0;
      pwm_request_i = 1'b0;
      tk(9);
      chk(fault_o === 4'h1 && !low_side_gate_o, "oc hold");
      off_on();
   endtask
   task t_uv();
      start();
      feedback_input_uv_i = 1'b1;
      tk(2);
      chk(fault_o === 4'h4 && power_good_out_oe_o === 1'b1, "uv");
      feedback_input_uv_i = 1'b0;
      off_on();
      freq_set_enable_pin_low_i = 1'b0;
      while (reference_step_o < 10'h320) tk(1);
      feedback_input_uv_i = 1'b1;
      tk(2);
      chk(phase_o === BSP_SS_RAMP && fault_o === 4'h0, "uv 80");
      feedback_input_uv_i = 1'b0;
      while (reference_step_o < 10'h335) tk(1);
      feedback_input_uv_i = 1'b1;
      tk(3);
      chk(phase_o === BSP_UV_RETRY && fault_o === 4'h0, "retry");
      feedback_input_uv_i = 1'b0;
      off_on();
      start();
   endtask
   task count_rr(output int n);
      n = 0;
      repeat (64) begin
         tk(1);
         n += int'(ramp_reset_o === 1'b1);
      end
   endtask
   task t_light();
      int n;
      light_load_i = 1'b1;
      pwm_request_i = 1'b1;
      tk(2);
      pwm_request_i = 1'b0;
      tk(8);
      chk(low_side_gate_o === 1'b0, "zero current");
      tk(7);
      pwm_request_i = 1'b1;
      tk(2);
      pwm_request_i = 1'b0;
      tk(15);
      chk(low_side_gate_o === 1'b0, "timer restart");
      tk(10);
      chk(low_side_gate_o === 1'b1, "timer expiry");
      {sync_enable_i, sync_in_range_i, run} = 3'h7;
      count_rr(n);
      chk(n > 0, "lock");
      sync_in_range_i = 1'b0;
      tk(20);
      count_rr(n);
      chk(n == 0, "out of range");
      {sync_enable_i, run, light_load_i} = 3'h0;
   endtask
   task t_ext();
      osc_ext_sel_i = 1'b1;
      tk(8);
      chk(osc_tick_o === 1'b0, "ext idle");
      osc_tick_ext_i = 1'b1;
      tk(1);
      osc_tick_ext_i = 1'b0;
      chk(osc_tick_o === 1'b1, "ext tick");
      osc_ext_sel_i = 1'b0;
   endtask
   initial begin
      #640000;
      fail_count++;
      $display("mismatch %0t watchdog", $time);
      results();
   end
   initial begin
      {rst_b_i, supply_ok_i, driver_supply_ok_i, run, osc_tick_ext_i} = '0;
      {osc_ext_sel_i, sync_enable_i, sync_in_range_i, pwm_request_i} = '0;
      {light_load_i, output_sense_ov_i, output_sense_below_half_i} = '0;
      {output_sense_pre_ov_i, feedback_input_uv_i} = '0;
      {current_sense_over20_i, current_sense_over30_i} = '0;
      freq_set_enable_pin_low_i = 1'b1;
      output_sense_in_window_i = 1'b1;
      tk(12);
      rst_b_i = 1'b1;
      t_guard();
      t_ov();
      t_oc();
      t_uv();
      t_light();
      t_ext();
      results();
   end
endmodule
`default_nettype wire
